/* File: design/tmf_pkg.sv */
// Package with transfer codes, packet widths and message carriers of the trace formatter.
package tmf_pkg;

  // ----------------------------------------------------------------
  // Transfer codes
  // ----------------------------------------------------------------
  localparam logic [5:0] TC_DEBUG_STATUS = 6'h00;
  localparam logic [5:0] TC_OWNERSHIP = 6'h02;
  localparam logic [5:0] TC_DIRECT_BRANCH = 6'h03;
  localparam logic [5:0] TC_INDIRECT_BRANCH = 6'h04;
  localparam logic [5:0] TC_DATA_WRITE = 6'h05;
  localparam logic [5:0] TC_DATA_READ = 6'h06;
  localparam logic [5:0] TC_ERROR = 6'h08;
  localparam logic [5:0] TC_PROGRAM_SYNC = 6'h09;
  localparam logic [5:0] TC_DIRECT_BRANCH_SYNC = 6'h0B;
  localparam logic [5:0] TC_INDIRECT_BRANCH_SYNC = 6'h0C;
  localparam logic [5:0] TC_DATA_WRITE_SYNC = 6'h0D;
  localparam logic [5:0] TC_DATA_READ_SYNC = 6'h0E;
  localparam logic [5:0] TC_WATCH_HIT = 6'h0F;
  localparam logic [5:0] TC_RESOURCE_FULL = 6'h1B;
  localparam logic [5:0] TC_CORRELATION = 6'h21;
  localparam logic [5:0] TC_TRACE_WATCH_HIT = 6'h38;
  localparam logic [5:0] TC_DIRECT_BRANCH_TARGET = 6'h39;
  localparam logic [5:0] TC_RMW_TRACE = 6'h3A;
  localparam logic [5:0] TC_RMW_TRACE_SYNC = 6'h3B;
  localparam logic [5:0] TC_VENDOR_EXT = 6'h3F;

  // ----------------------------------------------------------------
  // Packet widths in bits
  // ----------------------------------------------------------------
  localparam logic [5:0] W_TCODE = 6'h06;
  localparam logic [5:0] W_WORD = 6'h20;
  localparam logic [5:0] W_ICNT = 6'h08;
  localparam logic [5:0] W_EVTID = 6'h02;
  localparam logic [5:0] W_DSZ = 6'h02;
  localparam logic [5:0] W_RMW_TYPE = 6'h02;
  localparam logic [5:0] W_BITPOS = 6'h05;
  localparam logic [5:0] W_RCODE = 6'h04;
  localparam logic [5:0] W_RDATA = 6'h08;
  localparam logic [5:0] W_EVCODE = 6'h04;
  localparam logic [5:0] W_WPHIT = 6'h08;
  localparam logic [5:0] W_TWPHIT = 6'h02;
  localparam logic [5:0] W_ECODE = 6'h05;

  // ----------------------------------------------------------------
  // Sizes and carriers
  // ----------------------------------------------------------------
  localparam int AUX_W_DEF = 8;
  localparam int FIFO_DEPTH_DEF = 16;

  // One message request: code plus up to three packets, low bits used.
  typedef struct packed {
    logic [5:0] tcode;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [31:0] p3;
  } tmf_msg_t;

  // Layout of one message: packet count, widths and variable flags.
  typedef struct packed {
    logic ok;
    logic [1:0] npkt;
    logic [5:0] w1;
    logic [5:0] w2;
    logic [5:0] w3;
    logic v1;
    logic v2;
    logic v3;
  } tmf_fmt_t;

  // Layout lookup; any code not listed, 63 included, comes back not ok.
  function automatic tmf_fmt_t tmf_format(input logic [5:0] tc);
    tmf_fmt_t f;
    f = '0;
    f.ok = 1'b1;
    case (tc)
      TC_DEBUG_STATUS, TC_OWNERSHIP: f = '{1'b1, 2'h1, W_WORD, 6'h00, 6'h00, 1'b0, 1'b0, 1'b0};
      TC_ERROR: f = '{1'b1, 2'h1, W_ECODE, 6'h00, 6'h00, 1'b0, 1'b0, 1'b0};
      TC_DIRECT_BRANCH: f = '{1'b1, 2'h1, W_ICNT, 6'h00, 6'h00, 1'b1, 1'b0, 1'b0};
      TC_DIRECT_BRANCH_TARGET, TC_PROGRAM_SYNC, TC_DIRECT_BRANCH_SYNC:
        f = '{1'b1, 2'h2, W_ICNT, W_WORD, 6'h00, 1'b1, 1'b1, 1'b0};
      TC_INDIRECT_BRANCH, TC_INDIRECT_BRANCH_SYNC:
        f = '{1'b1, 2'h3, W_EVTID, W_ICNT, W_WORD, 1'b0, 1'b1, 1'b1};
      TC_RESOURCE_FULL: f = '{1'b1, 2'h2, W_RCODE, W_RDATA, 6'h00, 1'b0, 1'b1, 1'b0};
      TC_CORRELATION: f = '{1'b1, 2'h2, W_EVCODE, W_ICNT, 6'h00, 1'b0, 1'b1, 1'b0};
      TC_DATA_WRITE, TC_DATA_READ, TC_DATA_WRITE_SYNC, TC_DATA_READ_SYNC:
        f = '{1'b1, 2'h3, W_DSZ, W_WORD, W_WORD, 1'b0, 1'b1, 1'b0};
      TC_RMW_TRACE, TC_RMW_TRACE_SYNC:
        f = '{1'b1, 2'h3, W_RMW_TYPE, W_BITPOS, W_WORD, 1'b0, 1'b0, 1'b1};
      TC_WATCH_HIT: f = '{1'b1, 2'h1, W_WPHIT, 6'h00, 6'h00, 1'b0, 1'b0, 1'b0};
      TC_TRACE_WATCH_HIT: f = '{1'b1, 2'h1, W_TWPHIT, 6'h00, 6'h00, 1'b0, 1'b0, 1'b0};
      default: f = '0;
    endcase
    return f;
  endfunction

endpackage

/* File: design/tmf_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module tmf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only; no reset needed on the data words.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at DEPTH so non-power-of-two depths also work.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule
`default_nettype wire

/* File: design/tmf_formatter.sv */
// Trace message formatter: queues requests and serialises them onto the aux trace port.
`timescale 1ns/1ps
`default_nettype none
module tmf_formatter
  import tmf_pkg::*;
#(
  parameter int AUX_W = AUX_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Message requests from the debug logic
  input wire logic msg_valid,
  output logic msg_ready,
  input wire tmf_msg_t msg,
  // Dropped unknown-code request indication
  output logic msg_dropped,
  // Auxiliary trace port toward the tool
  output logic aux_valid,
  input wire logic aux_ready,
  output logic [AUX_W-1:0] aux_data,
  output logic aux_sop,
  output logic aux_eop,
  output logic aux_eom
);

  // ----------------------------------------------------------------
  // Types and storage
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMF_IDLE = 2'b00,
    TMF_CODE = 2'b01,
    TMF_PKT = 2'b11
  } tmf_state_t;

  tmf_state_t state_q;
  logic [31:0] sh_q;
  logic [5:0] beats_q;
  logic [1:0] pidx_q;
  logic [1:0] npkt_q;
  logic [31:0] pk_q [3];
  logic [5:0] w_q [3];
  logic v_q [3];
  logic drop_q;

  tmf_msg_t fifo_msg;
  logic fifo_valid;
  logic fifo_pop;
  tmf_fmt_t fmt;
  logic fire;
  logic last_beat;
  logic last_pkt;
  logic [1:0] nidx;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Keeps only the low w bits, so padding above the packet is zero.
  function automatic logic [31:0] keep_low(input logic [31:0] val, input logic [5:0] w);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      if (i < int'(w)) begin
        r[i] = val[i];
      end
    end
    return r;
  endfunction

  // Beats for one packet; a variable one counts only up to its top set bit.
  function automatic logic [5:0] beats_of(input logic [31:0] val, input logic [5:0] w,
                                          input logic v);
    int len;
    len = int'(w);
    if (v) begin
      len = 1;
      for (int i = 0; i < 32; i++) begin
        if (i < int'(w) && val[i]) begin
          len = i + 1;
        end
      end
    end
    return 6'((len + AUX_W - 1) / AUX_W);
  endfunction

  // ----------------------------------------------------------------
  // Request queue
  // ----------------------------------------------------------------
  // The queue soaks up bursts; msg_ready falls when it is full.
  tmf_fifo #(
    .WIDTH($bits(tmf_msg_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(msg_valid),
    .in_ready(msg_ready),
    .in_data(msg),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_msg)
  );

  // ----------------------------------------------------------------
  // Port handshake
  // ----------------------------------------------------------------
  // Requests are only taken between messages, so messages never interleave.
  assign fmt = tmf_format(fifo_msg.tcode);
  assign fifo_pop = (state_q == TMF_IDLE) && fifo_valid;
  assign aux_valid = (state_q != TMF_IDLE);
  assign aux_data = sh_q[AUX_W-1:0];
  assign fire = aux_valid && aux_ready;
  assign last_beat = (beats_q == 6'h01);
  assign last_pkt = (pidx_q == npkt_q - 2'h1);
  assign nidx = pidx_q + 2'h1;
  assign aux_sop = (state_q == TMF_CODE);
  assign aux_eop = (state_q == TMF_CODE) || ((state_q == TMF_PKT) && last_beat);
  assign aux_eom = (state_q == TMF_PKT) && last_beat && last_pkt;
  assign msg_dropped = drop_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Code beat first, then each packet in order, low bits first.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= TMF_IDLE;
    end else begin
      case (state_q)
        TMF_IDLE: begin
          if (fifo_pop && fmt.ok) begin
            state_q <= TMF_CODE;
          end
        end
        TMF_CODE: begin
          if (fire) begin
            state_q <= TMF_PKT;
          end
        end
        TMF_PKT: begin
          if (fire && last_beat && last_pkt) begin
            state_q <= TMF_IDLE;
          end
        end
        default: state_q <= TMF_IDLE;
      endcase
    end
  end

  // Unknown codes, including the vendor extension, are dropped with a pulse.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= fifo_pop && !fmt.ok;
    end
  end

  // Latches the packet layout and contents when a message is taken.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      npkt_q <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        pk_q[i] <= '0;
        w_q[i] <= '0;
        v_q[i] <= 1'b0;
      end
    end else if (fifo_pop && fmt.ok) begin
      npkt_q <= fmt.npkt;
      pk_q[0] <= keep_low(fifo_msg.p1, fmt.w1);
      pk_q[1] <= keep_low(fifo_msg.p2, fmt.w2);
      pk_q[2] <= keep_low(fifo_msg.p3, fmt.w3);
      w_q[0] <= fmt.w1;
      w_q[1] <= fmt.w2;
      w_q[2] <= fmt.w3;
      v_q[0] <= fmt.v1;
      v_q[1] <= fmt.v2;
      v_q[2] <= fmt.v3;
    end
  end

  // Shift register feeding the port; beats_q counts what is left of a packet.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_q <= '0;
      beats_q <= 6'h00;
      pidx_q <= 2'h0;
    end else begin
      case (state_q)
        TMF_IDLE: begin
          if (fifo_pop && fmt.ok) begin
            sh_q <= {26'h0, fifo_msg.tcode};
            beats_q <= 6'h01;
            pidx_q <= 2'h0;
          end
        end
        TMF_CODE: begin
          if (fire) begin
            sh_q <= pk_q[0];
            beats_q <= beats_of(pk_q[0], w_q[0], v_q[0]);
          end
        end
        TMF_PKT: begin
          if (fire && !last_beat) begin
            sh_q <= sh_q >> AUX_W;
            beats_q <= beats_q - 6'h01;
          end else if (fire && !last_pkt) begin
            sh_q <= pk_q[nidx];
            beats_q <= beats_of(pk_q[nidx], w_q[nidx], v_q[nidx]);
            pidx_q <= nidx;
          end
        end
        default: sh_q <= sh_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_hold_on_stall;
    aux_valid && !aux_ready |=> aux_valid && $stable(aux_data) && $stable(aux_eom);
  endproperty
  a_hold_on_stall: assert property (p_hold_on_stall) else $error("Beat changed while stalled.");

  property p_no_vendor_code;
    aux_sop |-> aux_data[5:0] != TC_VENDOR_EXT;
  endproperty
  a_no_vendor_code: assert property (p_no_vendor_code) else $error("Code 63 was sent.");

  property p_fixed_full;
    state_q == TMF_CODE && fire && !v_q[0] |=> beats_q == 6'((int'(w_q[0]) + AUX_W - 1) / AUX_W);
  endproperty
  a_fixed_full: assert property (p_fixed_full) else $error("Fixed packet was shortened.");

  property p_pad_zero;
    aux_valid && aux_eop && !aux_sop |-> (sh_q >> AUX_W) == '0;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("Bits left after packet end.");

  property p_direct_branch;
    fifo_pop && fifo_msg.tcode == TC_DIRECT_BRANCH |=> npkt_q == 2'h1 && w_q[0] == W_ICNT;
  endproperty
  a_direct_branch: assert property (p_direct_branch) else $error("Bad direct branch layout.");

  property p_indirect_branch;
    fifo_pop && fifo_msg.tcode == TC_INDIRECT_BRANCH
      |=> npkt_q == 2'h3 && w_q[0] == W_EVTID && w_q[1] == W_ICNT && w_q[2] == W_WORD;
  endproperty
  a_indirect_branch: assert property (p_indirect_branch) else $error("Bad indirect layout.");

  property p_data_write;
    fifo_pop && fifo_msg.tcode == TC_DATA_WRITE
      |=> npkt_q == 2'h3 && w_q[0] == W_DSZ && w_q[2] == W_WORD && !v_q[2];
  endproperty
  a_data_write: assert property (p_data_write) else $error("Bad data write layout.");

  property p_rmw;
    fifo_pop && fifo_msg.tcode == TC_RMW_TRACE |=> w_q[0] == W_RMW_TYPE && w_q[1] == W_BITPOS;
  endproperty
  a_rmw: assert property (p_rmw) else $error("Bad read-modify-write layout.");

  property p_code_first;
    fifo_pop && fmt.ok |=> aux_sop && aux_data[5:0] == $past(fifo_msg.tcode);
  endproperty
  a_code_first: assert property (p_code_first) else $error("Code beat did not lead.");

  property p_eom_then_idle;
    fire && aux_eom |=> !aux_valid ##1 (aux_sop || !aux_valid);
  endproperty
  a_eom_then_idle: assert property (p_eom_then_idle) else $error("Message ran on.");

  property p_drop_reserved;
    fifo_pop && fifo_msg.tcode == TC_VENDOR_EXT |=> msg_dropped && !aux_valid;
  endproperty
  a_drop_reserved: assert property (p_drop_reserved) else $error("Code 63 not dropped.");

  c_message_end: cover property (fire && aux_eom);
  c_stall: cover property (aux_valid && !aux_ready ##1 fire);
  c_full_queue: cover property (msg_valid && !msg_ready);
  c_dropped: cover property (msg_dropped);
  // Next message starts right after the single idle cycle that separates messages.
  c_back_to_back: cover property (fire && aux_eom ##2 aux_sop);

endmodule
`default_nettype wire

/* File: sim/tmf_tool_model.sv */
// Model of the external tool that takes beats off the aux trace port.
`timescale 1ns/1ps
`default_nettype none
module tmf_tool_model #(
  parameter int AUX_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pace from the bench: 0 fast, 1 slow, 2 stopped
  input wire logic [1:0] pace,
  // Aux trace port
  input wire logic aux_valid,
  output logic aux_ready,
  input wire logic [AUX_W-1:0] aux_data,
  input wire logic aux_sop,
  input wire logic aux_eop,
  input wire logic aux_eom,
  // Beats taken so far
  output logic [9:0] beat_cnt
);
  logic [AUX_W+2:0] beats [0:1023];
  logic [1:0] tick_q;

  // ----------------------------------------------------------------
  // Acceptance pace
  // ----------------------------------------------------------------
  // Free running tick; slow mode takes one beat in four so the sender must hold.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_q <= 2'h0;
    end else begin
      tick_q <= tick_q + 2'h1;
    end
  end

  assign aux_ready = (pace == 2'h0) || ((pace == 2'h1) && (tick_q == 2'h3));

  // ----------------------------------------------------------------
  // Beat capture
  // ----------------------------------------------------------------
  // Each beat is kept whole with its markers; parsing relies on port-width beats.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      beat_cnt <= 10'h000;
    end else if (aux_valid && aux_ready) begin
      beats[beat_cnt] <= {aux_sop, aux_eop, aux_eom, aux_data};
      beat_cnt <= beat_cnt + 10'h001;
    end
  end
endmodule
`default_nettype wire

/* File: sim/test_trace_message_formatter.sv */
// Self-checking bench for the trace message formatter.
`timescale 1ns/1ps
`default_nettype none
module test_trace_message_formatter
  import tmf_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic msg_valid = 1'b0;
  tmf_msg_t msg = '0;
  logic msg_ready, msg_dropped, aux_valid, aux_sop, aux_eop, aux_eom;
  logic [7:0] aux_data;
  logic aux_ready;
  logic [1:0] pace = 2'h0;
  logic [9:0] beat_cnt;
  logic [10:0] exp_q [$];
  int fails = 0;
  int comparisons = 0;
  int drops = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Clock, instances and monitors
  // ----------------------------------------------------------------
  always #25 clk = ~clk;

  tmf_formatter #(.AUX_W(8), .FIFO_DEPTH(16)) i_dut (
    .clk(clk), .rstn(rstn), .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg),
    .msg_dropped(msg_dropped), .aux_valid(aux_valid), .aux_ready(aux_ready),
    .aux_data(aux_data), .aux_sop(aux_sop), .aux_eop(aux_eop), .aux_eom(aux_eom)
  );

  tmf_tool_model #(.AUX_W(8)) i_tool (
    .clk(clk), .rstn(rstn), .pace(pace), .aux_valid(aux_valid), .aux_ready(aux_ready),
    .aux_data(aux_data), .aux_sop(aux_sop), .aux_eop(aux_eop), .aux_eom(aux_eom),
    .beat_cnt(beat_cnt)
  );

  // Drop pulses are counted here, and a hang is cut short by the cycle ceiling.
  always @(posedge clk) begin
    cycles++;
    if (msg_dropped === 1'b1) drops++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Expected stream
  // ----------------------------------------------------------------
  // Packet widths w1,w2,w3 and variable flags per code; zero width means absent.
  function automatic logic [20:0] lay(input logic [5:0] c);
    case (c)
      6'h00, 6'h02: return {6'd32, 6'd0, 6'd0, 3'b000};
      6'h08: return {6'd5, 6'd0, 6'd0, 3'b000};
      6'h03: return {6'd8, 6'd0, 6'd0, 3'b100};
      6'h39, 6'h09, 6'h0B: return {6'd8, 6'd32, 6'd0, 3'b110};
      6'h04, 6'h0C: return {6'd2, 6'd8, 6'd32, 3'b011};
      6'h1B, 6'h21: return {6'd4, 6'd8, 6'd0, 3'b010};
      6'h05, 6'h06, 6'h0D, 6'h0E: return {6'd2, 6'd32, 6'd32, 3'b010};
      6'h3A, 6'h3B: return {6'd2, 6'd5, 6'd32, 3'b001};
      6'h0F: return {6'd8, 6'd0, 6'd0, 3'b000};
      6'h38: return {6'd2, 6'd0, 6'd0, 3'b000};
      default: return '0;
    endcase
  endfunction

  // Variable packets lose leading zeros but still fill whole beats, low bits first.
  task automatic add_pkt(input logic [31:0] val, input int w, input bit v, input bit last);
    int len;
    int nb;
    val = (w == 32) ? val : (val & ((32'h1 << w) - 32'h1));
    len = w;
    if (v) begin
      len = 1;
      for (int i = 0; i < 32; i++) if (val[i]) len = i + 1;
    end
    nb = (len + 7) / 8;
    for (int i = 0; i < nb; i++) exp_q.push_back({1'b0, i == nb - 1, last && i == nb - 1, val[8*i +: 8]});
  endtask

  task automatic expect_msg(input logic [5:0] c, input logic [31:0] a, b, d);
    logic [20:0] l;
    l = lay(c);
    if (l != '0) begin
      exp_q.push_back({3'b110, 2'b00, c});
      add_pkt(a, int'(l[20:15]), l[2], l[14:9] == 6'd0);
      if (l[14:9] != 6'd0) add_pkt(b, int'(l[14:9]), l[1], l[8:3] == 6'd0);
      if (l[8:3] != 6'd0) add_pkt(d, int'(l[8:3]), l[0], 1'b1);
    end
  endtask

  // Leaves msg_valid high so back-to-back requests need no gap.
  task automatic send(input logic [5:0] c, input logic [31:0] a, b, d);
    expect_msg(c, a, b, d);
    msg = '{c, a, b, d};
    msg_valid = 1'b1;
    while (msg_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits for every expected beat, then checks order, markers and that nothing extra follows.
  task automatic drain_check();
    msg_valid = 1'b0;
    while (beat_cnt != 10'(exp_q.size())) @(posedge clk) #1;
    repeat (8) @(posedge clk) #1;
    check(32'(beat_cnt), 32'(exp_q.size()));
    for (int i = 0; i < exp_q.size(); i++) check(32'(i_tool.beats[i]), 32'(exp_q[i]));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every code with a layout, with junk above packet widths and zero variable packets.
  task automatic t_all_codes();
    logic [5:0] codes [19] = '{6'h00, 6'h02, 6'h08, 6'h03, 6'h39, 6'h04, 6'h09, 6'h0B, 6'h0C,
                               6'h1B, 6'h21, 6'h05, 6'h06, 6'h0D, 6'h0E, 6'h3A, 6'h3B, 6'h0F, 6'h38};
    for (int i = 0; i < 19; i++) send(codes[i], 32'hFEDC_BA98 >> i, 32'h0012_3456 << i, 32'h8000_0001);
    send(6'h03, 32'h0, 32'h0, 32'h0);
    send(6'h09, 32'h0000_0100, 32'h0, 32'h0);
    drain_check();
  endtask

  // Reserved codes give a drop pulse each and no beats; good traffic carries on.
  task automatic t_reserved();
    logic [5:0] res [9] = '{6'h01, 6'h07, 6'h0A, 6'h10, 6'h1A, 6'h1C, 6'h22, 6'h3C, 6'h3F};
    int d0;
    d0 = drops;
    for (int i = 0; i < 9; i++) send(res[i], 32'h1, 32'h2, 32'h3);
    send(6'h04, 32'h1, 32'h2, 32'h1234);
    drain_check();
    check(32'(drops - d0), 32'd9);
  endtask

  // The tool stops, the queue fills until refused, then drains slowly in order.
  task automatic t_fill();
    int n;
    pace = 2'h2;
    msg_valid = 1'b1;
    n = 0;
    while (msg_ready === 1'b1 && n < 40) begin
      msg = '{6'h03, 32'(n), 32'h0, 32'h0};
      expect_msg(6'h03, 32'(n), 32'h0, 32'h0);
      @(posedge clk) #1;
      n++;
    end
    // One message sits in the sequencer, the rest fill the queue to its depth.
    check(32'(n), 32'(FIFO_DEPTH_DEF + 1));
    // A request held against a full queue must be refused and never show up.
    msg = '{6'h03, 32'h0000_00FF, 32'h0, 32'h0};
    repeat (3) begin
      check(32'(msg_ready), 32'h0);
      @(posedge clk) #1;
    end
    msg_valid = 1'b0;
    pace = 2'h1;
    drain_check();
    pace = 2'h0;
  endtask

  task automatic wrap_up();
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk) #1;
    t_all_codes();
    t_reserved();
    t_fill();
    wrap_up();
  end
endmodule
`default_nettype wire
